// >>> src/lsa_pkg.sv
// package for the load/store access unit: operation codes, sizes, trap codes
// assumes a single core clock and a decode stage that presents one op per request
package lsa_pkg;
    localparam int unsigned XLEN = 64;
    localparam int unsigned IMM_W = 13;
    localparam int unsigned ASI_W = 8;
    localparam int unsigned VA_BITS = 48;
    // default address space for plain (non-alternate) accesses
    localparam logic [7:0] ASI_PRIMARY = 8'h80;
    // alternate spaces below this need privilege
    localparam logic [7:0] ASI_UNRESTRICTED = 8'h80;
    localparam logic [7:0] ASI_HYPER_LO = 8'h30;
    // privilege modes
    localparam logic [1:0] MODE_USER = 2'h0;
    localparam logic [1:0] MODE_PRIV = 2'h1;
    localparam logic [1:0] MODE_HYPER = 2'h2;
    // access size codes: bytes = 1 << size
    localparam logic [2:0] SZ_BYTE = 3'h0;
    localparam logic [2:0] SZ_HALF = 3'h1;
    localparam logic [2:0] SZ_WORD = 3'h2;
    localparam logic [2:0] SZ_DWORD = 3'h3;
    localparam logic [2:0] SZ_QUAD = 3'h4;
    // trap codes
    localparam logic [2:0] TRAP_NONE = 3'h0;
    localparam logic [2:0] TRAP_ALIGN = 3'h1;
    localparam logic [2:0] TRAP_RANGE = 3'h2;
    localparam logic [2:0] TRAP_PRIV = 3'h3;
    localparam logic [2:0] TRAP_FPOFF = 3'h4;
    localparam logic [2:0] TRAP_ILLEGAL = 3'h5;
    localparam logic [2:0] TRAP_EMUL = 3'h6;
    // operation classes
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LOAD = 4'h1,
        OP_STORE = 4'h2,
        OP_FLOAD = 4'h3,
        OP_FSTORE = 4'h4,
        OP_CAS = 4'h5,
        OP_LDSET = 4'h6,
        OP_TWIN = 4'h7,
        OP_PREFETCH = 4'h8,
        OP_OTHER = 4'h9
    } lsa_op_e;
    // unit states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1
    } lsa_state_e;
endpackage : lsa_pkg

// >>> src/lsa_unit.sv
// load/store access unit: address generation, checks, byte order, extension
// assumes decode holds req until accepted; memory answers mem_ack once per request
// Contract
// [RULE1] only load, store, load-store and prefetch ops reach memory
// [RULE2] address is reg+reg or reg+sign-extended 13-bit immediate, 64 bits
// [RULE3] every request carries an address space id
// [RULE4] alternate accesses carry an 8-bit id chosen by the instruction
// [RULE5] data names one or two int regs, or one, two or four fp regs; compare-swap and load-set accept any register count
// [RULE6] integer sizes: byte, halfword, word, extended word
// [RULE7] narrow integer loads sign or zero extend to 64 bits
// [RULE8] float sizes: word, doubleword, quadword
// [RULE9] compare-swap and byte load-set are one atomic read-modify-write
// [RULE10] twin doubleword load is one atomic 128-bit access
// [RULE11] quad float load raises an emulation exception
// [RULE12] misaligned accesses raise a trap; prefetches skip the alignment check and issue
// [RULE13] alignment tested on low address bits; failing access suppressed
// [RULE14] big-endian: address names most significant byte
// [RULE15] instruction fetches always big-endian
// [RULE16] little-endian: address names least significant byte
// [RULE17] valid addresses are the low and high halves of n-bit space
// [RULE18] integer regs 64 bits, fp operands 32, 64 or 128 bits
// [RULE19] insufficient privilege traps instead of executing
// [RULE20] fp op with unit disabled raises the fp-off trap
// [RULE21] with no fp unit built it behaves as permanently disabled
// [RULE22] out-of-range address blocked and reported as range trap
module lsa_unit #(
    parameter bit HAS_FPU = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from decode
    input wire logic req_valid,
    output logic req_ready,
    input wire lsa_pkg::lsa_op_e req_op,
    input wire logic [2:0] req_size,
    input wire logic req_signed,
    input wire logic req_use_imm,
    input wire logic [63:0] req_rs1,
    input wire logic [63:0] req_rs2,
    input wire logic [12:0] req_imm,
    input wire logic req_alt,
    input wire logic [7:0] req_asi,
    input wire logic req_little,
    input wire logic req_ifetch,
    input wire logic [1:0] req_regs,
    input wire logic [127:0] req_wdata,
    input wire logic [63:0] req_cmp,
    input wire logic [1:0] cur_mode,
    input wire logic fpu_enable,
    // memory side
    output logic mem_valid,
    output logic [63:0] mem_addr,
    output logic [7:0] mem_asi,
    output logic [2:0] mem_size,
    output logic mem_we,
    output logic mem_atomic,
    output logic mem_prefetch,
    output logic [127:0] mem_wdata,
    output logic [63:0] mem_cmp,
    input wire logic mem_ack,
    input wire logic [127:0] mem_rdata,
    // result and trap
    output logic res_valid,
    output logic [127:0] res_data,
    output logic [2:0] trap_code,
    output logic trap_valid
);
    import lsa_pkg::*;

    // reverse bytes within the low nbytes of a 128-bit lane
    function automatic logic [127:0] swap_bytes(input logic [127:0] d, input logic [2:0] sz);
        logic [127:0] r;
        int n;
        r = '0;
        n = 1 << sz;
        for (int i = 0; i < 16; i++) begin
            if (i < n) begin
                r[8*i +: 8] = d[8*(n-1-i) +: 8];
            end
        end
        return r;
    endfunction : swap_bytes

    lsa_state_e state_r;
    logic [63:0] ea;
    logic [63:0] imm_ext;
    logic mem_class;
    logic is_fp;
    logic is_store;
    logic [3:0] low_mask;
    logic misalign;
    logic in_range;
    logic priv_bad;
    logic fp_off;
    logic size_bad;
    logic quad_load;
    logic [2:0] trap_nxt;
    logic accept;
    logic little_eff;
    logic [2:0] size_r;
    logic signed_r;
    logic little_r;
    logic [127:0] rd_ordered;
    logic [127:0] ext_data;

    // effective address from two regs or reg plus sign-extended immediate
    assign imm_ext = {{(XLEN-IMM_W){req_imm[12]}}, req_imm}; // RULE2
    assign ea = req_rs1 + (req_use_imm ? imm_ext : req_rs2); // RULE2
    // classify operation
    assign mem_class = (req_op != OP_NONE) && (req_op != OP_OTHER); // RULE1
    assign is_fp = (req_op == OP_FLOAD) || (req_op == OP_FSTORE);
    assign is_store = (req_op == OP_STORE) || (req_op == OP_FSTORE) ||
                      (req_op == OP_CAS) || (req_op == OP_LDSET);
    // legal sizes per class and register counts
    assign size_bad = is_fp ? ((req_size < SZ_WORD) || (req_size > SZ_QUAD) ||
                               (req_regs != req_size[1:0] - 2'h2 + 2'h0 && // RULE8
                                !(req_size == SZ_QUAD && req_regs == 2'h2) &&
                                !(req_size == SZ_DWORD && req_regs == 2'h1) &&
                                !(req_size == SZ_WORD && req_regs == 2'h0)))
                    : (req_op == OP_TWIN) ? (req_size != SZ_QUAD || req_regs != 2'h1) // RULE5
                    : (req_op == OP_LDSET) ? (req_size != SZ_BYTE) // RULE9
                    : (req_op == OP_CAS) ? (req_size != SZ_WORD && req_size != SZ_DWORD)
                    : (req_size > SZ_DWORD) || (req_regs > 2'h1); // RULE6 RULE18
    assign quad_load = (req_op == OP_FLOAD) && (req_size == SZ_QUAD); // RULE11
    // alignment test on low address bits
    assign low_mask = 4'((16'h1 << req_size) - 16'h1);
    assign misalign = (req_op != OP_PREFETCH) && ((ea[3:0] & low_mask) != 4'h0); // RULE12 RULE13
    // virtual range: upper bits must all equal bit n-1
    assign in_range = (ea[63:VA_BITS-1] == '0) || (ea[63:VA_BITS-1] == '1); // RULE17
    // privilege of alternate space
    assign priv_bad = req_alt && ((req_asi < ASI_HYPER_LO && cur_mode == MODE_USER) ||
                      (req_asi < ASI_UNRESTRICTED && req_asi >= ASI_HYPER_LO &&
                       cur_mode != MODE_HYPER)); // RULE19
    assign fp_off = is_fp && (!HAS_FPU || !fpu_enable); // RULE20 RULE21
    // trap priority: illegal, privilege, fp off, emulation, alignment, range
    assign trap_nxt = !mem_class ? TRAP_ILLEGAL :
                      size_bad ? TRAP_ILLEGAL :
                      priv_bad ? TRAP_PRIV :
                      fp_off ? TRAP_FPOFF :
                      quad_load ? TRAP_EMUL : // RULE11
                      misalign ? TRAP_ALIGN : // RULE13
                      !in_range ? TRAP_RANGE : TRAP_NONE; // RULE22
    assign req_ready = (state_r == ST_IDLE);
    assign accept = req_valid && req_ready;
    // fetches ignore the data byte order
    assign little_eff = req_little && !req_ifetch; // RULE15 RULE16

    // issue stage: register the request or trap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            mem_valid <= 1'b0;
            mem_addr <= '0;
            mem_asi <= '0;
            mem_size <= '0;
            mem_we <= 1'b0;
            mem_atomic <= 1'b0;
            mem_prefetch <= 1'b0;
            mem_wdata <= '0;
            mem_cmp <= '0;
            trap_valid <= 1'b0;
            trap_code <= TRAP_NONE;
            size_r <= '0;
            signed_r <= 1'b0;
            little_r <= 1'b0;
        end else begin
            trap_valid <= 1'b0;
            if (state_r == ST_WAIT && mem_ack) begin
                state_r <= ST_IDLE;
                mem_valid <= 1'b0;
            end
            if (accept) begin
                trap_code <= trap_nxt;
                if (trap_nxt != TRAP_NONE) begin
                    trap_valid <= 1'b1; // RULE13 RULE22
                end else begin
                    state_r <= ST_WAIT;
                    mem_valid <= 1'b1; // RULE1
                    mem_addr <= ea;
                    mem_asi <= req_alt ? req_asi : ASI_PRIMARY; // RULE3 RULE4
                    mem_size <= req_size;
                    mem_we <= is_store;
                    mem_atomic <= (req_op == OP_CAS) || (req_op == OP_LDSET) ||
                                  (req_op == OP_TWIN); // RULE9 RULE10
                    mem_prefetch <= (req_op == OP_PREFETCH);
                    mem_wdata <= little_eff ? req_wdata : swap_bytes(req_wdata, req_size); // RULE14
                    mem_cmp <= req_cmp;
                    size_r <= req_size;
                    signed_r <= req_signed && (req_op == OP_LOAD);
                    little_r <= little_eff;
                end
            end
        end
    end

    // memory lane 0 holds the lowest address; reorder to significance
    assign rd_ordered = little_r ? mem_rdata : swap_bytes(mem_rdata, size_r); // RULE14 RULE16
    // extend narrow integer loads
    always_comb begin
        ext_data = rd_ordered;
        case (size_r)
            SZ_BYTE: ext_data = {64'h0, {56{signed_r & rd_ordered[7]}}, rd_ordered[7:0]}; // RULE7
            SZ_HALF: ext_data = {64'h0, {48{signed_r & rd_ordered[15]}}, rd_ordered[15:0]};
            SZ_WORD: ext_data = {64'h0, {32{signed_r & rd_ordered[31]}}, rd_ordered[31:0]};
            SZ_DWORD: ext_data = {64'h0, rd_ordered[63:0]};
            default: ext_data = rd_ordered;
        endcase
    end

    // result register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            res_valid <= 1'b0;
            res_data <= '0;
        end else begin
            res_valid <= (state_r == ST_WAIT) && mem_ack;
            if ((state_r == ST_WAIT) && mem_ack) begin
                res_data <= ext_data;
            end
        end
    end

    // assertions: trapped requests never reach memory
    a_no_trap_issue: assert property (@(posedge clk) disable iff (rst) // RULE13
        accept && trap_nxt != TRAP_NONE |=> !mem_valid)
        else $error("trapped op issued");

    a_other_blocked: assert property (@(posedge clk) disable iff (rst) // RULE1
        accept && !mem_class |=> trap_valid && trap_code == TRAP_ILLEGAL)
        else $error("non-memory op not trapped");

    a_misalign_block: assert property (@(posedge clk) disable iff (rst) // RULE13
        accept && misalign |=> !mem_valid)
        else $error("misaligned op issued");

    a_range_block: assert property (@(posedge clk) disable iff (rst) // RULE22
        accept && !in_range |=> !mem_valid)
        else $error("out-of-range op issued");

    a_align_check: assert property (@(posedge clk) disable iff (rst) // RULE12
        mem_valid && !mem_prefetch |-> (mem_addr[3:0] & 4'((16'h1 << mem_size) - 16'h1)) == 4'h0)
        else $error("misaligned issue");

    a_range_ok: assert property (@(posedge clk) disable iff (rst) // RULE17
        mem_valid |-> (mem_addr[63:VA_BITS-1] == '0) || (mem_addr[63:VA_BITS-1] == '1))
        else $error("out-of-range issue");

    a_no_pf_write: assert property (@(posedge clk) disable iff (rst) // RULE1
        mem_valid |-> !(mem_we && mem_prefetch))
        else $error("prefetch marked as write");

    // trap decisions for privilege, the floating-point unit, register counts and sizes
    a_fp_off: assert property (@(posedge clk) disable iff (rst) // RULE20 RULE21
        accept && is_fp && (!fpu_enable || !HAS_FPU) && mem_class && !size_bad && !priv_bad
        |=> trap_valid && trap_code == TRAP_FPOFF)
        else $error("fp off missed");

    a_quad_emul: assert property (@(posedge clk) disable iff (rst) // RULE11
        accept && quad_load && !size_bad && !priv_bad && !fp_off
        |=> trap_valid && trap_code == TRAP_EMUL)
        else $error("quad float load not trapped");

    a_priv_trap: assert property (@(posedge clk) disable iff (rst) // RULE19
        accept && mem_class && !size_bad && priv_bad |=> trap_code == TRAP_PRIV)
        else $error("privilege not trapped");

    a_int_regs: assert property (@(posedge clk) disable iff (rst) // RULE5
        accept && mem_class && !is_fp && req_op != OP_TWIN && req_regs > 2'h1
        |=> trap_valid && trap_code == TRAP_ILLEGAL)
        else $error("bad integer register count");

    a_fp_regs: assert property (@(posedge clk) disable iff (rst) // RULE5 RULE8
        accept && is_fp && req_size == SZ_QUAD && req_regs != 2'h2
        |=> trap_valid && trap_code == TRAP_ILLEGAL)
        else $error("bad fp register count");

    a_int_size: assert property (@(posedge clk) disable iff (rst) // RULE6 RULE18
        accept && trap_nxt == TRAP_NONE && (req_op == OP_LOAD || req_op == OP_STORE)
        |-> req_size <= SZ_DWORD)
        else $error("integer size too wide");

    // address and address space of issued requests
    a_addr_sum: assert property (@(posedge clk) disable iff (rst) // RULE2
        accept && trap_nxt == TRAP_NONE |=> mem_addr == $past(ea))
        else $error("bad address");

    a_imm_sext: assert property (@(posedge clk) disable iff (rst) // RULE2
        accept && trap_nxt == TRAP_NONE && req_use_imm
        |=> mem_addr == $past(req_rs1) + {{51{$past(req_imm[12])}}, $past(req_imm)})
        else $error("immediate not sign extended");

    a_asi_plain: assert property (@(posedge clk) disable iff (rst) // RULE3
        accept && trap_nxt == TRAP_NONE && !req_alt |=> mem_asi == ASI_PRIMARY)
        else $error("asi missing");

    a_asi_alt: assert property (@(posedge clk) disable iff (rst) // RULE4
        accept && trap_nxt == TRAP_NONE && req_alt |=> mem_asi == $past(req_asi))
        else $error("alternate asi lost");

    // atomic operations
    a_atomic_cas: assert property (@(posedge clk) disable iff (rst) // RULE9
        accept && trap_nxt == TRAP_NONE && req_op == OP_CAS |=> mem_atomic && mem_we)
        else $error("cas not atomic");

    a_atomic_ldset: assert property (@(posedge clk) disable iff (rst) // RULE9
        accept && trap_nxt == TRAP_NONE && req_op == OP_LDSET
        |=> mem_atomic && mem_we && mem_size == SZ_BYTE)
        else $error("byte load-set not atomic");

    a_atomic_twin: assert property (@(posedge clk) disable iff (rst) // RULE10
        accept && trap_nxt == TRAP_NONE && req_op == OP_TWIN
        |=> mem_atomic && !mem_we && mem_size == SZ_QUAD)
        else $error("twin load not one atomic access");

    a_plain_split: assert property (@(posedge clk) disable iff (rst) // RULE9
        accept && trap_nxt == TRAP_NONE && (req_op == OP_LOAD || req_op == OP_STORE)
        |=> !mem_atomic)
        else $error("plain access marked atomic");

    // byte order of store data and of fetches
    a_big_store: assert property (@(posedge clk) disable iff (rst) // RULE14
        accept && trap_nxt == TRAP_NONE && !little_eff && req_size == SZ_WORD
        |=> mem_wdata[7:0] == $past(req_wdata[31:24]))
        else $error("big-endian lane order wrong");

    a_little_store: assert property (@(posedge clk) disable iff (rst) // RULE16
        accept && trap_nxt == TRAP_NONE && little_eff && req_size == SZ_WORD
        |=> mem_wdata[31:0] == $past(req_wdata[31:0]))
        else $error("little-endian lane order wrong");

    a_fetch_big: assert property (@(posedge clk) disable iff (rst) // RULE15
        accept && trap_nxt == TRAP_NONE && req_ifetch |=> !little_r)
        else $error("fetch not big-endian");

    // memory handshake and result
    a_mem_hold: assert property (@(posedge clk) disable iff (rst)
        mem_valid && !mem_ack |=> mem_valid && $stable(mem_addr) && $stable(mem_size))
        else $error("request dropped before ack");

    a_mem_drop: assert property (@(posedge clk) disable iff (rst)
        mem_valid && mem_ack |=> !mem_valid)
        else $error("request held after ack");

    a_res_follows: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_WAIT && mem_ack |=> res_valid)
        else $error("result lost");

    a_res_pulse: assert property (@(posedge clk) disable iff (rst)
        res_valid |=> !res_valid)
        else $error("result longer than one cycle");

    // load extension
    a_zero_ext: assert property (@(posedge clk) disable iff (rst) // RULE7
        res_valid && !signed_r && size_r == SZ_BYTE |-> res_data[127:8] == '0)
        else $error("byte load not zero extended");

    a_sign_ext: assert property (@(posedge clk) disable iff (rst) // RULE7
        res_valid && signed_r && size_r == SZ_HALF |-> res_data[63:16] == {48{res_data[15]}})
        else $error("halfword load not sign extended");

    // main scenarios
    c_load_done: cover property (@(posedge clk) disable iff (rst) res_valid);
    c_align_trap: cover property (@(posedge clk) disable iff (rst)
        trap_valid && trap_code == TRAP_ALIGN);
    c_twin_issue: cover property (@(posedge clk) disable iff (rst) mem_valid && mem_size == SZ_QUAD);
    c_fp_off_trap: cover property (@(posedge clk) disable iff (rst)
        trap_valid && trap_code == TRAP_FPOFF);
endmodule : lsa_unit

// >>> bench/lsa_mem_model.sv
// memory side model: acks each request one or four cycles after mem_valid rises, with a byte pattern
// assumes mem_valid stays up until the edge where mem_ack is seen
module lsa_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the unit
    input wire logic mem_valid,
    input wire logic [63:0] mem_addr,
    input wire logic slow,
    // answer
    output logic mem_ack,
    output logic [127:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_r;
    // lane k answers pattern of address + k; outside the ack cycle the data keep toggling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= '0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_r <= slow ? 2'h3 : 2'h0; // slow answers take three extra cycles
        end else if (mem_valid && wait_r == 2'h0) begin
            mem_ack <= 1'b1;
            for (int k = 0; k < 16; k++) begin
                mem_rdata[8*k +: 8] <= (mem_addr[7:0] + 8'(k)) ^ 8'h9c;
            end
        end else begin
            mem_rdata <= ~mem_rdata;
            wait_r <= mem_valid ? wait_r - 2'h1 : wait_r;
        end
    end
endmodule : lsa_mem_model

// >>> bench/tb.sv
// testbench of the load/store access unit against a reference model with random traffic
// assumes the memory model answers every request; one request outstanding at a time
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lsa_pkg::*;
    logic clk, rst, req_valid, req_ready, req_signed, req_use_imm, req_alt, req_little;
    logic req_ifetch, fpu_enable, mem_valid, mem_we, mem_atomic, mem_prefetch, mem_ack;
    logic res_valid, trap_valid, slow, got_trap, got_res, saw_mem, m_we, m_atomic, m_pf;
    lsa_op_e req_op;
    logic [2:0] req_size, mem_size, trap_code, got_code, m_size;
    logic [1:0] req_regs, cur_mode;
    logic [63:0] req_rs1, req_rs2, req_cmp, mem_addr, mem_cmp, m_addr, seed;
    logic [12:0] req_imm;
    logic [7:0] req_asi, mem_asi, m_asi;
    logic [127:0] req_wdata, mem_wdata, mem_rdata, res_data, m_wdata, r_data;
    int bad_count, n_checks;
    // unit under test and its memory side
    lsa_unit u_lsa_unit (.clk, .rst, .req_valid, .req_ready, .req_op, .req_size, .req_signed,
        .req_use_imm, .req_rs1, .req_rs2, .req_imm, .req_alt, .req_asi, .req_little,
        .req_ifetch, .req_regs, .req_wdata, .req_cmp, .cur_mode, .fpu_enable, .mem_valid,
        .mem_addr, .mem_asi, .mem_size, .mem_we, .mem_atomic, .mem_prefetch, .mem_wdata,
        .mem_cmp, .mem_ack, .mem_rdata, .res_valid, .res_data, .trap_code, .trap_valid);
    lsa_mem_model u_lsa_mem_model (.clk, .rst, .mem_valid, .mem_addr, .slow, .mem_ack,
        .mem_rdata);
    // xorshift source seeded with 42
    function automatic logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    // raise a request for one edge, then watch settled outputs until trap or result
    task automatic issue();
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        {got_trap, got_res, saw_mem} = 3'b000;
        for (int c = 0; c < 30 && !got_trap && !got_res; c++) begin
            @(negedge clk);
            if (trap_valid === 1'b1) begin
                {got_trap, got_code} = {1'b1, trap_code};
            end
            if (mem_valid === 1'b1 && !saw_mem) begin
                {saw_mem, m_addr, m_asi, m_size, m_we} = {1'b1, mem_addr, mem_asi, mem_size, mem_we};
                {m_atomic, m_pf, m_wdata} = {mem_atomic, mem_prefetch, mem_wdata};
            end
            if (res_valid === 1'b1) begin
                {got_res, r_data} = {1'b1, res_data};
            end
        end
    endtask : issue
    // fixed request in privileged mode; trap code 7 means a trap of any code and no memory access are expected
    task automatic dir(input lsa_op_e op, input logic [2:0] sz, input logic [1:0] rg,
            input logic fen, input logic [63:0] a, input logic [2:0] et, input logic [1:0] ap);
        @(posedge clk);
        {req_op, req_size, req_regs, fpu_enable, req_rs1} <= {op, sz, rg, fen, a};
        {req_rs2, req_use_imm, req_alt, cur_mode} <= {64'h0, 1'b0, 1'b0, MODE_PRIV};
        issue();
        if (et == 3'h7 || et != TRAP_NONE) begin
            chk({saw_mem, got_trap}, 2'b01);
            if (et != 3'h7) chk(got_code, et);
        end else begin
            chk({saw_mem, m_size, m_atomic, m_pf}, {1'b1, sz, ap});
        end
    endtask : dir
    // clock and reset
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #1_000_000;
        bad_count++;
        close_out();
    end
    initial begin
        logic [63:0] r, rs1, rs2, ea, ofs, v;
        logic [127:0] wd, ex, msk;
        logic [2:0] sz, et;
        logic [1:0] md;
        logic st, ui, alt, lil, ifet, sg, big, pv;
        int n;
        {seed, bad_count, n_checks, rst, req_valid, slow} = {64'd42, 32'd0, 32'd0, 3'b100};
        {req_op, req_size, req_signed, req_use_imm, req_rs1, req_rs2, req_imm} = '0;
        {req_alt, req_asi, req_little, req_ifetch, req_regs, req_wdata, req_cmp} = '0;
        {cur_mode, fpu_enable} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            {st, sz, ui, alt, lil, sg, md} = {r[0], 1'b0, r[2:1], r[10], r[27], r[36], r[38], r[26:25]};
            {ifet, rs1, rs2, wd} = {r[37] & ~r[0], rnd(), 59'h0, r[8:4], rnd(), rnd()};
            if (r[9:8] != 2'h0) rs1[63:47] = {17{r[3]}};
            ofs = ui ? {{51{r[23]}}, r[23:11]} : rs2;
            ea = rs1 + ofs;
            if (r[24]) rs1 = rs1 - {61'h0, ea[2:0]};
            ea = rs1 + ofs;
            if (md == 2'h3) md = MODE_USER;
            @(posedge clk);
            {req_op, req_size, req_regs, req_signed, req_use_imm} <= {st ? OP_STORE : OP_LOAD, sz, 2'h0, sg, ui};
            {req_rs1, req_rs2, req_imm, req_alt, req_asi} <= {rs1, rs2, r[23:11], alt, r[35:28]};
            {req_little, req_ifetch, cur_mode, req_wdata, req_cmp} <= {lil, ifet, md, wd, r};
            {slow, fpu_enable} <= r[40:39];
            issue();
            n = 1 << sz;
            pv = alt && (r[35:28] < ASI_HYPER_LO ? md == MODE_USER
                : r[35:28] < ASI_UNRESTRICTED && md != MODE_HYPER);
            et = pv ? TRAP_PRIV : (ea & 64'(n - 1)) != 0 ? TRAP_ALIGN
                : (ea[63:VA_BITS-1] != '0 && ~ea[63:VA_BITS-1] != '0) ? TRAP_RANGE : TRAP_NONE;
            big = !lil || ifet;
            {v, ex, msk} = '0;
            for (int k = 0; k < n; k++) begin
                msk[8*k +: 8] = 8'hff;
                ex[8*k +: 8] = big ? wd[8*(n-1-k) +: 8] : wd[8*k +: 8];
                if (big) v = {v[55:0], (ea[7:0] + 8'(k)) ^ 8'h9c};
                else v[8*k +: 8] = (ea[7:0] + 8'(k)) ^ 8'h9c;
            end
            if (sg && sz != SZ_DWORD && v[8*n-1]) v = v | ~((64'h1 << (8*n)) - 64'h1);
            if (et != TRAP_NONE) begin
                chk({got_trap, got_code, saw_mem}, {1'b1, et, 1'b0});
            end else begin
                chk({saw_mem, got_res, m_addr, m_size, m_we}, {2'b11, ea, sz, st});
                chk(m_asi, alt ? r[35:28] : ASI_PRIMARY);
                if (st) chk(m_wdata & msk, ex);
                else chk(r_data, {64'h0, v});
            end
        end
        dir(OP_FLOAD, SZ_WORD, 2'h0, 1'b0, 64'h1000, TRAP_FPOFF, 2'b00);
        dir(OP_FLOAD, SZ_WORD, 2'h0, 1'b1, 64'h1000, TRAP_NONE, 2'b00);
        dir(OP_FSTORE, SZ_DWORD, 2'h1, 1'b1, 64'h1000, TRAP_NONE, 2'b00);
        dir(OP_FSTORE, SZ_QUAD, 2'h2, 1'b1, 64'h1000, TRAP_NONE, 2'b00);
        dir(OP_FLOAD, SZ_QUAD, 2'h2, 1'b1, 64'h1000, TRAP_EMUL, 2'b00);
        dir(OP_CAS, SZ_WORD, 2'h0, 1'b1, 64'h1000, TRAP_NONE, 2'b10);
        dir(OP_CAS, SZ_DWORD, 2'h0, 1'b1, 64'h1000, TRAP_NONE, 2'b10);
        dir(OP_LDSET, SZ_BYTE, 2'h0, 1'b1, 64'h1003, TRAP_NONE, 2'b10);
        dir(OP_TWIN, SZ_QUAD, 2'h1, 1'b1, 64'h1000, TRAP_NONE, 2'b10);
        dir(OP_PREFETCH, SZ_DWORD, 2'h0, 1'b1, 64'h1003, TRAP_NONE, 2'b01);
        dir(OP_OTHER, SZ_WORD, 2'h0, 1'b1, 64'h1000, 3'h7, 2'b00);
        close_out();
    end
endmodule : tb
